/* File: pct_cmp.v */
// Purpose : Compares a measured value, normalised to percent of its
//           full-scale reference, against a percent threshold.
// Assumes : Threshold in tenths of a percent; full scale nonzero.
// Notes   : Cross-multiplies instead of dividing, so no divider is
//           needed; result is exact for any nonzero full-scale value.
`timescale 1ns/1ns
`default_nettype none
`include "relay_defines.vh"

module pct_cmp #(
  parameter VAL_W = 16,
  parameter FS_W  = 16,
  parameter THR_W = `RLY_THR_W
) (
  input  wire [VAL_W-1:0] i_val,  // Measured value
  input  wire [FS_W-1:0]  i_fs,   // Full-scale reference of i_val
  input  wire [THR_W-1:0] i_thr,  // Threshold, tenths of a percent
  output wire             o_ge,   // Normalised value >= threshold
  output wire             o_lt,   // Normalised value <  threshold
  output wire             o_gt    // Normalised value >  threshold
);

  localparam PW = VAL_W + FS_W + THR_W;

  // ========================================================================
  // Normalisation
  // val/fs*1000 >= thr  <=>  val*1000 >= thr*fs
  wire [PW-1:0] val_ext;
  wire [PW-1:0] fs_ext;
  wire [PW-1:0] thr_ext;
  wire [PW-1:0] pct_ext;
  wire [PW-1:0] lhs;
  wire [PW-1:0] rhs;

  assign val_ext = {{(FS_W+THR_W){1'b0}}, i_val};
  assign fs_ext  = {{(VAL_W+THR_W){1'b0}}, i_fs};
  assign thr_ext = {{(VAL_W+FS_W){1'b0}}, i_thr};
  assign pct_ext = {{(PW-`RLY_THR_W){1'b0}}, `RLY_PCT_FULL};
  assign lhs     = val_ext * pct_ext;
  assign rhs     = thr_ext * fs_ext;

  // ========================================================================
  // Comparison
  assign o_ge = (lhs >= rhs);
  assign o_lt = (lhs <  rhs);
  assign o_gt = (lhs >  rhs);

endmodule
`default_nettype wire

/* File: relay_defines.vh */
// Purpose : Constants for the relay output function selector.
// Assumes : Threshold and normalised values are in tenths of a percent.
// Notes   : Definitions only; included by bare name.
`ifndef RELAY_DEFINES_VH
`define RELAY_DEFINES_VH

// ==========================================================================
// Selector field
`define RLY_SEL_W        4
`define RLY_SEL_MAX      4'h9
`define RLY_SEL_RST      4'h1
`define RLY_SRC_N        10

// ==========================================================================
// Selector codes
`define RLY_SEL_RUN      4'h0
`define RLY_SEL_HEALTHY  4'h1
`define RLY_SEL_AT_SPEED 4'h2
`define RLY_SEL_TRIPPED  4'h3
`define RLY_SEL_FREQ_GE  4'h4
`define RLY_SEL_CUR_GE   4'h5
`define RLY_SEL_FREQ_LT  4'h6
`define RLY_SEL_CUR_LT   4'h7
`define RLY_SEL_AIN2_GT  4'h8
`define RLY_SEL_READY    4'h9

// ==========================================================================
// Source vector bit positions (bit index equals selector code)
`define RLY_BIT_RUN      0
`define RLY_BIT_HEALTHY  1
`define RLY_BIT_AT_SPEED 2
`define RLY_BIT_TRIPPED  3
`define RLY_BIT_FREQ_GE  4
`define RLY_BIT_CUR_GE   5
`define RLY_BIT_FREQ_LT  6
`define RLY_BIT_CUR_LT   7
`define RLY_BIT_AIN2_GT  8
`define RLY_BIT_READY    9

// ==========================================================================
// Threshold, tenths of a percent: 0.0 .. 200.0 %, reset 100.0 %
`define RLY_THR_W        11
`define RLY_THR_MAX      11'h7d0
`define RLY_THR_RST      11'h3e8

// Full scale expressed in tenths of a percent (100.0 %)
`define RLY_PCT_FULL     11'h3e8

`endif

/* File: relay_func_sel.v */
// Purpose : Drives one relay contact from a selectable drive condition.
// Assumes : All status and measurement inputs come from logic on
//           i_core_clk; selector and threshold arrive with write strobes.
// Notes   : One cycle from a status or measurement change to the relay output, two from a selector or threshold write.
//           At-speed is raw equality with no tolerance band, so a
//           setpoint that the ramp never hits exactly leaves it open.
//           A zero full scale is not guarded; keep full scales nonzero.
//           Status inputs are same-clock logic and are not synchronised.
`timescale 1ns/1ns
`default_nettype none
`include "relay_defines.vh"

module relay_func_sel #(
  parameter FREQ_W = 16,
  parameter CUR_W  = 16,
  parameter AIN_W  = 12
) (
  input  wire                   i_core_clk,    // Control clock, 100 MHz
  input  wire                   i_rstn,        // Async reset, active low
  input  wire                   i_sel_we,      // Selector write strobe
  input  wire [`RLY_SEL_W-1:0]  i_sel_val,     // Selector write value
  input  wire                   i_thr_we,      // Threshold write strobe
  input  wire [`RLY_THR_W-1:0]  i_thr_val,     // Threshold, 0.1 % units
  input  wire                   i_running,     // Motor output enabled
  input  wire                   i_powered,     // Drive power present
  input  wire                   i_fault,       // Any fault present
  input  wire                   i_tripped,     // Drive in tripped state
  input  wire                   i_ready,       // Drive ready to run
  input  wire [FREQ_W-1:0]      i_out_freq,    // Output frequency
  input  wire [FREQ_W-1:0]      i_set_freq,    // Setpoint frequency
  input  wire [FREQ_W-1:0]      i_freq_fs,     // Frequency full scale
  input  wire [CUR_W-1:0]       i_motor_cur,   // Motor current
  input  wire [CUR_W-1:0]       i_cur_fs,      // Current full scale
  input  wire [AIN_W-1:0]       i_ain2,        // Analog input 2 value
  input  wire [AIN_W-1:0]       i_ain2_fs,     // Analog input 2 full scale
  output wire                   o_relay_close, // Contact closed when high
  output wire [`RLY_SEL_W-1:0]  o_sel,         // Active selector
  output wire [`RLY_THR_W-1:0]  o_thr,         // Active threshold
  output wire [`RLY_SRC_N-1:0]  o_src_vec,     // All sources, registered
  output wire                   o_sel_rej,     // Selector write refused
  output wire                   o_thr_rej      // Threshold write refused
);

  // ========================================================================
  // Selector register
  reg  [`RLY_SEL_W-1:0] sel_q;
  reg  [`RLY_SEL_W-1:0] sel_d;
  reg                   sel_rej_q;
  reg                   sel_rej_d;
  wire                  sel_ok;

  // Out-of-range codes are refused so the relay never falls to a
  // meaningless source; the previous choice stays in force.
  assign sel_ok = (i_sel_val <= `RLY_SEL_MAX);

  always @* begin
    sel_d     = sel_q;
    sel_rej_d = 1'b0;
    if (i_sel_we) begin
      if (sel_ok) begin
        sel_d = i_sel_val;
      end else begin
        sel_rej_d = 1'b1;
      end
    end
  end

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sel_q <= `RLY_SEL_RST;
    end else begin
      sel_q <= sel_d;
    end
  end

  // The refusal flag lasts one cycle; it is not sticky.
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sel_rej_q <= 1'b0;
    end else begin
      sel_rej_q <= sel_rej_d;
    end
  end

  // ========================================================================
  // Threshold register
  reg  [`RLY_THR_W-1:0] thr_q;
  reg  [`RLY_THR_W-1:0] thr_d;
  reg                   thr_rej_q;
  reg                   thr_rej_d;
  wire                  thr_ok;

  // Over-range thresholds are refused like selector codes, never clamped.
  assign thr_ok = (i_thr_val <= `RLY_THR_MAX);

  always @* begin
    thr_d     = thr_q;
    thr_rej_d = 1'b0;
    if (i_thr_we) begin
      if (thr_ok) begin
        thr_d = i_thr_val;
      end else begin
        thr_rej_d = 1'b1;
      end
    end
  end

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      thr_q <= `RLY_THR_RST;
    end else begin
      thr_q <= thr_d;
    end
  end

  // Same one-cycle refusal pulse as the selector.
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      thr_rej_q <= 1'b0;
    end else begin
      thr_rej_q <= thr_rej_d;
    end
  end

  // ========================================================================
  // Normalised comparisons against the shared threshold
  wire freq_ge;
  wire freq_lt;
  wire cur_ge;
  wire cur_lt;
  wire ain2_gt;

  // One threshold feeds all three comparators
  pct_cmp #(
    .VAL_W (FREQ_W),
    .FS_W  (FREQ_W),
    .THR_W (`RLY_THR_W)
  ) u_freq_cmp (
    .i_val (i_out_freq),
    .i_fs  (i_freq_fs),
    .i_thr (thr_q),
    .o_ge  (freq_ge),
    .o_lt  (freq_lt),
    .o_gt  ()
  );

  // Current: >= serves code 5 and < serves code 7
  pct_cmp #(
    .VAL_W (CUR_W),
    .FS_W  (CUR_W),
    .THR_W (`RLY_THR_W)
  ) u_cur_cmp (
    .i_val (i_motor_cur),
    .i_fs  (i_cur_fs),
    .i_thr (thr_q),
    .o_ge  (cur_ge),
    .o_lt  (cur_lt),
    .o_gt  ()
  );

  // Analog input 2 uses the strict compare only
  pct_cmp #(
    .VAL_W (AIN_W),
    .FS_W  (AIN_W),
    .THR_W (`RLY_THR_W)
  ) u_ain2_cmp (
    .i_val (i_ain2),
    .i_fs  (i_ain2_fs),
    .i_thr (thr_q),
    .o_ge  (),
    .o_lt  (),
    .o_gt  (ain2_gt)
  );

  // ========================================================================
  // Status-derived sources
  // Each term is named once so the vector and the selector read the
  // same logic; ready is masked by a trip even if the ready flag lags
  // behind the trip that should have dropped it.
  wire run_src;
  wire healthy_src;
  wire at_speed_src;
  wire trip_src;
  wire ready_src;

  assign run_src      = i_running;
  assign healthy_src  = i_powered & ~i_fault;
  assign at_speed_src = (i_out_freq == i_set_freq);
  assign trip_src     = i_tripped;
  assign ready_src    = i_ready & ~i_tripped;

  // ========================================================================
  // Source vector, bit index equals selector code
  reg [`RLY_SRC_N-1:0] src_d;

  always @* begin
    src_d                    = {`RLY_SRC_N{1'b0}};
    src_d[`RLY_BIT_RUN]      = run_src;
    src_d[`RLY_BIT_HEALTHY]  = healthy_src;
    src_d[`RLY_BIT_AT_SPEED] = at_speed_src;
    src_d[`RLY_BIT_TRIPPED]  = trip_src;
    src_d[`RLY_BIT_FREQ_GE]  = freq_ge;
    src_d[`RLY_BIT_CUR_GE]   = cur_ge;
    src_d[`RLY_BIT_FREQ_LT]  = freq_lt;
    src_d[`RLY_BIT_CUR_LT]   = cur_lt;
    src_d[`RLY_BIT_AIN2_GT]  = ain2_gt;
    src_d[`RLY_BIT_READY]    = ready_src;
  end

  // ========================================================================
  // Source selection
  // A plain case keeps each code explicit; the default covers codes
  // that the selector register can never hold.
  reg relay_d;

  always @* begin
    case (sel_q)
      `RLY_SEL_RUN: begin
        relay_d = src_d[`RLY_BIT_RUN];
      end
      `RLY_SEL_HEALTHY: begin
        relay_d = src_d[`RLY_BIT_HEALTHY];
      end
      `RLY_SEL_AT_SPEED: begin
        relay_d = src_d[`RLY_BIT_AT_SPEED];
      end
      `RLY_SEL_TRIPPED: begin
        relay_d = src_d[`RLY_BIT_TRIPPED];
      end
      `RLY_SEL_FREQ_GE: begin
        relay_d = src_d[`RLY_BIT_FREQ_GE];
      end
      `RLY_SEL_CUR_GE: begin
        relay_d = src_d[`RLY_BIT_CUR_GE];
      end
      `RLY_SEL_FREQ_LT: begin
        relay_d = src_d[`RLY_BIT_FREQ_LT];
      end
      `RLY_SEL_CUR_LT: begin
        relay_d = src_d[`RLY_BIT_CUR_LT];
      end
      `RLY_SEL_AIN2_GT: begin
        relay_d = src_d[`RLY_BIT_AIN2_GT];
      end
      `RLY_SEL_READY: begin
        relay_d = src_d[`RLY_BIT_READY];
      end
      default: begin
        relay_d = 1'b0;
      end
    endcase
  end

  // ========================================================================
  // Output registers
  // The relay is re-evaluated on every edge; no dwell filter is applied,
  // so a source toggling each cycle reaches the coil driver as is.
  reg                  relay_q;
  reg [`RLY_SRC_N-1:0] src_q;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      relay_q <= 1'b0;
    end else begin
      relay_q <= relay_d;
    end
  end

  // The vector is sampled on the same edge as the relay so both agree.
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      src_q <= {`RLY_SRC_N{1'b0}};
    end else begin
      src_q <= src_d;
    end
  end

  assign o_relay_close = relay_q;
  assign o_sel         = sel_q;
  assign o_thr         = thr_q;
  assign o_src_vec     = src_q;
  assign o_sel_rej     = sel_rej_q;
  assign o_thr_rej     = thr_rej_q;

endmodule
`default_nettype wire

/* File: relay_func_sel_props.sv */
// Purpose: Port assertions for relay_func_sel
// Assumes: One clock, async active-low reset
// Notes  : Bound into every instance
`timescale 1ns/1ns
`default_nettype none
`include "relay_defines.vh"
module relay_func_sel_props (
  input wire logic                  i_core_clk,    // Clock
  input wire logic                  i_rstn,        // Reset
  input wire logic                  i_sel_we,      // Sel strobe
  input wire logic [`RLY_SEL_W-1:0] i_sel_val,     // Sel value
  input wire logic                  i_thr_we,      // Thr strobe
  input wire logic [`RLY_THR_W-1:0] i_thr_val,     // Thr value
  input wire logic                  i_running,     // Running
  input wire logic                  i_powered,     // Powered
  input wire logic                  i_fault,       // Fault
  input wire logic                  i_tripped,     // Tripped
  input wire logic                  i_ready,       // Ready
  input wire logic                  o_relay_close, // Contact
  input wire logic [`RLY_SEL_W-1:0] o_sel,         // Sel
  input wire logic [`RLY_THR_W-1:0] o_thr,         // Thr
  input wire logic [`RLY_SRC_N-1:0] o_src_vec,     // Sources
  input wire logic                  o_sel_rej,     // Sel refused
  input wire logic                  o_thr_rej      // Thr refused
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  // ==========================================
  // Selector and threshold writes
  AST_SEL_MAX: assert property (o_sel <= 4'h9)
    else $error("selector out of range");
  AST_SEL_WR: assert property (i_sel_we && i_sel_val <= 4'h9 |=> o_sel == $past(i_sel_val))
    else $error("selector write lost");
  AST_SEL_REJ: assert property (i_sel_we && i_sel_val > 4'h9 |=> o_sel_rej && $stable(o_sel))
    else $error("bad selector taken");
  AST_THR_REJ: assert property (i_thr_we && i_thr_val > 11'h7d0 |=> o_thr_rej && $stable(o_thr))
    else $error("bad threshold taken");
  // ==========================================
  // Sources, one cycle behind their inputs
  AST_RUN: assert property (1'b1 |=> o_src_vec[0] == $past(i_running))
    else $error("run source wrong");
  AST_HEALTHY: assert property (1'b1 |=> o_src_vec[1] == $past(i_powered && !i_fault))
    else $error("healthy source wrong");
  AST_TRIP: assert property (1'b1 |=> o_src_vec[3] == $past(i_tripped))
    else $error("trip source wrong");
  AST_READY: assert property (1'b1 |=> o_src_vec[9] == $past(i_ready && !i_tripped))
    else $error("ready source wrong");
  AST_FREQ_CMP: assert property (1'b1 |=> o_src_vec[4] != o_src_vec[6])
    else $error("freq compares agree");
  AST_CUR_CMP: assert property (1'b1 |=> o_src_vec[5] != o_src_vec[7])
    else $error("current compares agree");
  AST_CONTACT: assert property (o_relay_close == o_src_vec[$past(o_sel)])
    else $error("contact not selected source");
  CVR_SEL_REJ: cover property (o_sel_rej);
  CVR_THR_REJ: cover property (o_thr_rej);
  CVR_CLOSE: cover property ($rose(o_relay_close));
endmodule
bind relay_func_sel relay_func_sel_props i_props (.*);
`default_nettype wire

/* File: relay_func_sel_tb.sv */
// Purpose: Self-checking bench for relay_func_sel
// Assumes: Inputs change on the falling edge
// Notes  : Full scales differ so normalising is exercised
`timescale 1ns/1ns
`default_nettype none
module relay_func_sel_tb;
  logic        clk = 0, rstn = 0, sel_we = 0, thr_we = 0;
  logic        run = 0, pwr = 1, flt = 0, trip = 0, rdy = 0;
  logic [3:0]  sel_val = 4'h0;
  logic [10:0] thr_val = 11'h000;
  logic [15:0] ofreq = 16'h0000, sfreq = 16'h0001, ffs = 16'h07d0, cur = 16'h0000, cfs = 16'h03e8;
  logic [11:0] ain = 12'h000, afs = 12'hfa0;
  wire         relay, sel_rej, thr_rej, load;
  wire [3:0]   sel;
  wire [10:0]  thr;
  wire [9:0]   src;
  int          errors = 0, checks = 0, cycles = 0;
  relay_func_sel i_dut (.i_core_clk(clk), .i_rstn(rstn), .i_sel_we(sel_we), .i_sel_val(sel_val),
    .i_thr_we(thr_we), .i_thr_val(thr_val), .i_running(run), .i_powered(pwr), .i_fault(flt),
    .i_tripped(trip), .i_ready(rdy), .i_out_freq(ofreq), .i_set_freq(sfreq), .i_freq_fs(ffs),
    .i_motor_cur(cur), .i_cur_fs(cfs), .i_ain2(ain), .i_ain2_fs(afs), .o_relay_close(relay),
    .o_sel(sel), .o_thr(thr), .o_src_vec(src), .o_sel_rej(sel_rej), .o_thr_rej(thr_rej));
  relay_load_model i_load (.i_contact_closed(relay), .o_load_on(load));
  initial begin
    forever #5 clk = ~clk;
  end
  // Cut a hang short; the run needs well under 200 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      tally_and_finish;
    end
  end
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  task automatic chk_val(input logic [10:0] got, input logic [10:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h", $time, what, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr_sel(input logic [3:0] v);
    sel_we = 1;
    sel_val = v;
    step(1);
    sel_we = 0;
  endtask
  task automatic wr_thr(input logic [10:0] v);
    thr_we = 1;
    thr_val = v;
    step(1);
    thr_we = 0;
  endtask
  // Drive status lines for one cycle and judge the contact and load
  task automatic st(input logic r, p, f, t, y, e);
    {run, pwr, flt, trip, rdy} = {r, p, f, t, y};
    step(1);
    chk_bit(relay, e, "contact");
    chk_bit(load, e, "load");
  endtask
  task automatic t_status;
    wr_sel(4'h0);
    st(1, 1, 0, 0, 0, 1);
    st(0, 1, 0, 0, 0, 0);
    wr_sel(4'h1);
    st(0, 1, 1, 0, 0, 0);
    st(0, 0, 0, 0, 0, 0);
    wr_sel(4'h2);
    sfreq = 16'h0000;
    st(0, 1, 0, 0, 0, 1);
    sfreq = 16'h0001;
    st(0, 1, 0, 0, 0, 0);
    wr_sel(4'h3);
    st(0, 1, 0, 1, 0, 1);
    st(0, 1, 0, 0, 0, 0);
    wr_sel(4'h9);
    st(0, 1, 0, 0, 1, 1);
    st(0, 1, 0, 1, 1, 0);
    $display("t_status done");
  endtask
  task automatic t_thresh;
    wr_thr(11'h1f4);
    ofreq = 16'h03e8;
    cur = 16'h01f3;
    ain = 12'h7d1;
    step(1);
    chk_val(11'(src[8:4]), 11'h019, "compares at limit");
    ofreq = 16'h03e7;
    cur = 16'h01f4;
    ain = 12'h7d0;
    step(1);
    chk_val(11'(src[8:4]), 11'h006, "compares below");
    wr_sel(4'h8);
    ain = 12'h7d1;
    st(0, 1, 0, 0, 0, 1);
    wr_sel(4'h3);
    wr_thr(11'h000);
    st(0, 1, 0, 1, 0, 1);
    st(0, 1, 0, 0, 0, 0);
    $display("t_thresh done");
  endtask
  task automatic t_refuse;
    sel_we = 1;
    sel_val = 4'h4;
    step(1);
    sel_val = 4'ha;
    step(1);
    sel_we = 0;
    chk_bit(sel_rej, 1, "sel refuse");
    chk_val(11'(sel), 11'h004, "sel kept");
    wr_sel(4'h9);
    chk_bit(sel_rej, 0, "sel pulse");
    chk_val(11'(sel), 11'h009, "sel max");
    wr_thr(11'h7d1);
    chk_bit(thr_rej, 1, "thr refuse");
    wr_thr(11'h7d0);
    chk_val(thr, 11'h7d0, "thr max");
    $display("t_refuse done");
  endtask
  initial begin
    step(4);
    chk_val(11'(sel), 11'h001, "sel reset");
    chk_val(thr, 11'h3e8, "thr reset");
    chk_bit(relay, 0, "contact reset");
    rstn = 1;
    step(1);
    chk_bit(relay, 1, "healthy after reset");
    $display("t_reset done");
    t_status;
    t_thresh;
    t_refuse;
    tally_and_finish;
  end
endmodule
`default_nettype wire

/* File: relay_load_model.sv */
// Purpose: Lamp load wired across the relay contact
// Assumes: Sense line has a pull-down
// Notes  : Open contact reads low, never a held value
`timescale 1ns/1ns
`default_nettype none
module relay_load_model (
  input  wire logic i_contact_closed, // Contact state
  output wire logic o_load_on         // Load energised
);
  assign o_load_on = (i_contact_closed === 1'b1) ? 1'b1 : 1'b0;
endmodule
`default_nettype wire
